/* File: rtl/pmsc_regs.vh */
// command codes, field positions, reset values and limits of the bank
`ifndef PMSC_REGS_VH
`define PMSC_REGS_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PMSC_CMD_TEMP_STATUS 8'h7d
`define PMSC_CMD_COMM_STATUS 8'h7e
`define PMSC_CMD_VIN_READ 8'h88
`define PMSC_CMD_VOUT_READ 8'h8b
`define PMSC_CMD_IOUT_READ 8'h8c
`define PMSC_CMD_TEMP_READ 8'h8d
`define PMSC_CMD_MODULE_TYPE 8'hd0
`define PMSC_CMD_VOUT_GAIN 8'hd1
`define PMSC_CMD_VOUT_OFFSET 8'hd2
`define PMSC_CMD_VIN_GAIN 8'hd3
`define PMSC_CMD_VIN_OFFSET 8'hd4
`define PMSC_CMD_IOUT_GAIN 8'hd6
`define PMSC_CMD_IOUT_OFFSET 8'hd7
`define PMSC_CMD_FW_REV 8'hdb
`define PMSC_CMD_PIN_CONFIG 8'he0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMSC_TEMP_OVER_TEMPERATURE_FAULT_FLAG_BIT 7
`define PMSC_TEMP_OVER_TEMPERATURE_WARNING_FLAG_BIT 6
`define PMSC_COMM_BAD_CMD_BIT 7
`define PMSC_COMM_BAD_DATA_BIT 6
`define PMSC_COMM_PEC_BIT 5
`define PMSC_MTYPE_WP_BIT 1
`define PMSC_CFG_ARA_BIT 4
`define PMSC_SUMMARY_TEMP_BIT 2
`define PMSC_SUMMARY_COMM_BIT 1

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define PMSC_GAIN_RESET 16'h2000
`define PMSC_GAIN_MIN 16'h1999
`define PMSC_GAIN_MAX 16'h2666
`define PMSC_OFFSET_RESET 16'h0000
`define PMSC_WP_RESET 1'b1
`define PMSC_CFG_RESET 5'h00
`define PMSC_PIN_CODE_MAX 4'h2
// linear exponents, five bit two's complement in bits 15:11
`define PMSC_EXP_VOUT 5'h14
`define PMSC_EXP_VIN 5'h1d
`define PMSC_EXP_IOUT 5'h1c

`endif

/* File: rtl/pmsc_flag.v */
// one sticky status flag where a set wins over a clear
`timescale 1ns/1ps
module pmsc_flag
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // control
  input wire set,
  input wire clr,
  // state
  output reg flag_q
);

  // ----------------------------------------------------------------
  // sticky flag
  // ----------------------------------------------------------------
  // an event in the clearing cycle is kept
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      flag_q <= 1'b0;
    else if (set)
      flag_q <= 1'b1;
    else if (clr)
      flag_q <= 1'b0;
  end

endmodule // pmsc_flag

/* File: rtl/pmsc_bank.v */
// status and calibration command bank of the power module
`timescale 1ns/1ps
`include "pmsc_regs.vh"
module pmsc_bank
#(
  // firmware revision, major in upper nibble
  parameter [7:0] FW_REVISION = 8'h10,
  // module designation, arbitrary neutral value, bit 5 = isolated
  parameter [5:0] DESIGNATION = 6'h2a,
  // one on the passive load sharing build
  parameter LOAD_SHARE = 0
)
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // command port from the bus protocol engine
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  output reg [15:0] cmd_rdata_q,
  output reg cmd_done_q,
  // events from the device logic and protocol engine
  input wire over_temperature_fault_flag_evt,
  input wire over_temperature_warning_flag_evt,
  input wire pec_error_evt,
  input wire alert_active,
  // telemetry from the measurement logic
  input wire [15:0] vin_reading,
  input wire [15:0] vout_reading,
  input wire [15:0] iout_reading,
  input wire [15:0] temp_reading,
  // summary bits towards the status word
  output wire temp_summary,
  output wire comm_summary,
  // calibration factors towards the measurement logic
  output reg [15:0] vout_read_gain_trim_q,
  output reg [15:0] vout_read_offset_trim_q,
  output reg [15:0] vin_read_gain_trim_q,
  output reg [15:0] vin_read_offset_trim_q,
  output reg [15:0] iout_gain_trim_q,
  output reg [15:0] iout_offset_trim_q,
  // configuration outputs
  output wire write_protect_flag,
  output wire ara_only,
  output wire trim_or_control_pin_is_trim,
  output wire trim_or_control_pin_is_onoff,
  output wire second_control_pin_is_pgood,
  output wire second_control_pin_is_onoff
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [4:0] mdesig_q; // writable designation bits 4:0
  reg write_protect_q; // write protect of the module-type word
  reg [4:0] cfg_q; // alert bit and pin code
  wire [4:0] flag_set; // sticky flag set vector
  wire [4:0] flag_clr; // sticky flag clear vector
  wire [4:0] flag_q; // sticky flags
  wire [7:0] temp_status; // temperature status byte
  wire [7:0] comm_status; // communication status byte
  wire [15:0] module_type_word; // assembled module-type word

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire wr = cmd_valid & cmd_write; // write request this cycle
  wire rd = cmd_valid & ~cmd_write; // read request this cycle
  reg known; // code is in the map
  reg writable; // code accepts writes
  reg [15:0] rd_value; // read data of the addressed code

  // code classification and read mux
  always @*
  begin
    known = 1'b1;
    writable = 1'b0;
    rd_value = 16'h0000;
    case (cmd_code)
      // status bytes, cleared by writing ones
      `PMSC_CMD_TEMP_STATUS:
      begin
        writable = 1'b1;
        rd_value = {8'h00, temp_status};
      end
      `PMSC_CMD_COMM_STATUS:
      begin
        writable = 1'b1;
        rd_value = {8'h00, comm_status};
      end
      // telemetry levels pass straight through
      `PMSC_CMD_VIN_READ: rd_value = vin_reading;
      `PMSC_CMD_VOUT_READ: rd_value = vout_reading;
      `PMSC_CMD_IOUT_READ: rd_value = iout_reading;
      `PMSC_CMD_TEMP_READ: rd_value = temp_reading;
      `PMSC_CMD_MODULE_TYPE:
      begin
        writable = 1'b1;
        rd_value = module_type_word;
      end
      // calibration trims
      `PMSC_CMD_VOUT_GAIN:
      begin
        writable = 1'b1;
        rd_value = vout_read_gain_trim_q;
      end
      `PMSC_CMD_VOUT_OFFSET:
      begin
        writable = 1'b1;
        rd_value = vout_read_offset_trim_q;
      end
      `PMSC_CMD_VIN_GAIN:
      begin
        writable = 1'b1;
        rd_value = vin_read_gain_trim_q;
      end
      `PMSC_CMD_VIN_OFFSET:
      begin
        writable = 1'b1;
        rd_value = vin_read_offset_trim_q;
      end
      `PMSC_CMD_IOUT_GAIN:
      begin
        writable = 1'b1;
        rd_value = iout_gain_trim_q;
      end
      `PMSC_CMD_IOUT_OFFSET:
      begin
        writable = 1'b1;
        rd_value = iout_offset_trim_q;
      end
      // read only, writes are an invalid command
      `PMSC_CMD_FW_REV: rd_value = {8'h00, FW_REVISION};
      `PMSC_CMD_PIN_CONFIG:
      begin
        writable = 1'b1;
        rd_value = {11'h000, cfg_q};
      end
      // any other code is outside the map
      default: known = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // write checks
  // ----------------------------------------------------------------
  // gain window shared by all three gain trims
  wire gain_ok = (cmd_wdata >= `PMSC_GAIN_MIN) &&
                 (cmd_wdata <= `PMSC_GAIN_MAX);
  wire [4:0] wexp = cmd_wdata[15:11]; // exponent of a linear word
  // pin code allowed on this build
  wire pin_ok = (LOAD_SHARE != 0) ? (cmd_wdata[3:0] == 4'h0)
              : (cmd_wdata[3:0] <= `PMSC_PIN_CODE_MAX);
  reg data_ok; // written value is acceptable
  reg is_trim; // code is a calibration trim

  // value check per code
  always @*
  begin
    data_ok = 1'b1;
    is_trim = 1'b0;
    case (cmd_code)
      // the three gains share one window
      `PMSC_CMD_VOUT_GAIN, `PMSC_CMD_VIN_GAIN, `PMSC_CMD_IOUT_GAIN:
      begin
        is_trim = 1'b1;
        data_ok = gain_ok;
      end
      // offsets must carry their fixed exponent
      `PMSC_CMD_VOUT_OFFSET:
      begin
        is_trim = 1'b1;
        data_ok = (wexp == `PMSC_EXP_VOUT);
      end
      `PMSC_CMD_VIN_OFFSET:
      begin
        is_trim = 1'b1;
        data_ok = (wexp == `PMSC_EXP_VIN);
      end
      `PMSC_CMD_IOUT_OFFSET:
      begin
        is_trim = 1'b1;
        data_ok = (wexp == `PMSC_EXP_IOUT);
      end
      // pin code checked against the build
      `PMSC_CMD_PIN_CONFIG: data_ok = pin_ok;
      default: data_ok = 1'b1;
    endcase
  end

  // a trim write under protection is locked out
  wire locked = is_trim & write_protect_q;
  // command not in the map, or a write to a read-only code
  wire bad_cmd = cmd_valid & (~known | (cmd_write & ~writable));
  // write refused for its value or the lock
  wire bad_data = wr & known & writable & (~data_ok | locked);
  // write that updates a register
  wire wr_ok = wr & known & writable & data_ok & ~locked;

  // ----------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------
  // order: over_temperature_fault_flag, over_temperature_warning_flag, bad cmd, bad data, pec
  assign flag_set = {over_temperature_fault_flag_evt, over_temperature_warning_flag_evt, bad_cmd, bad_data,
                     pec_error_evt};
  wire wr_temp = wr & (cmd_code == `PMSC_CMD_TEMP_STATUS);
  wire wr_comm = wr & (cmd_code == `PMSC_CMD_COMM_STATUS);
  // writing a one to a status bit clears it
  assign flag_clr = {
    wr_temp & cmd_wdata[`PMSC_TEMP_OVER_TEMPERATURE_FAULT_FLAG_BIT],
    wr_temp & cmd_wdata[`PMSC_TEMP_OVER_TEMPERATURE_WARNING_FLAG_BIT],
    wr_comm & cmd_wdata[`PMSC_COMM_BAD_CMD_BIT],
    wr_comm & cmd_wdata[`PMSC_COMM_BAD_DATA_BIT],
    wr_comm & cmd_wdata[`PMSC_COMM_PEC_BIT]};

  // one flag cell per supported bit
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_flag
      pmsc_flag u_flag
      (
        .clk(clk),
        .resetn(resetn),
        .set(flag_set[gi]),
        .clr(flag_clr[gi]),
        .flag_q(flag_q[gi])
      );
    end
  endgenerate

  // status bytes, unsupported and reserved bits fixed at zero
  assign temp_status = {flag_q[4], flag_q[3], 6'h00};
  assign comm_status = {flag_q[2], flag_q[1], flag_q[0],
                        5'h00};
  // summary bits for the status word
  assign temp_summary = |temp_status;
  assign comm_summary = |comm_status;

  // ----------------------------------------------------------------
  // module-type word
  // ----------------------------------------------------------------
  // top designation bit is fixed by the build, high byte zero
  assign module_type_word = {8'h00, DESIGNATION[5], mdesig_q,
                             write_protect_q, 1'b0};
  assign write_protect_flag = write_protect_q;

  // designation and protect bits, protection on from reset
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mdesig_q <= 5'h00;
      write_protect_q <= `PMSC_WP_RESET;
    end
    else if (wr_ok && cmd_code == `PMSC_CMD_MODULE_TYPE)
    begin
      // word writes are never locked, bit 0 and high byte ignored
      mdesig_q <= cmd_wdata[6:2];
      write_protect_q <= cmd_wdata[`PMSC_MTYPE_WP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // calibration trims
  // ----------------------------------------------------------------
  // trims keep their value; the nonvolatile copy lives outside
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      // gains at the factor default, offsets at zero
      vout_read_gain_trim_q <= `PMSC_GAIN_RESET;
      vout_read_offset_trim_q <= `PMSC_OFFSET_RESET;
      vin_read_gain_trim_q <= `PMSC_GAIN_RESET;
      vin_read_offset_trim_q <= `PMSC_OFFSET_RESET;
      iout_gain_trim_q <= `PMSC_GAIN_RESET;
      iout_offset_trim_q <= `PMSC_OFFSET_RESET;
    end
    else if (wr_ok)
    begin
      // only accepted, unlocked writes reach here
      case (cmd_code)
        `PMSC_CMD_VOUT_GAIN: vout_read_gain_trim_q <= cmd_wdata;
        `PMSC_CMD_VOUT_OFFSET: vout_read_offset_trim_q <= cmd_wdata;
        `PMSC_CMD_VIN_GAIN: vin_read_gain_trim_q <= cmd_wdata;
        `PMSC_CMD_VIN_OFFSET: vin_read_offset_trim_q <= cmd_wdata;
        `PMSC_CMD_IOUT_GAIN: iout_gain_trim_q <= cmd_wdata;
        `PMSC_CMD_IOUT_OFFSET: iout_offset_trim_q <= cmd_wdata;
        // other codes leave every trim alone
        default: iout_offset_trim_q <= iout_offset_trim_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // alert and pin configuration
  // ----------------------------------------------------------------
  // reserved bits 7:5 never stored, byte resets to zero
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cfg_q <= `PMSC_CFG_RESET;
    else if (wr_ok && cmd_code == `PMSC_CMD_PIN_CONFIG)
      cfg_q <= cmd_wdata[4:0];
  end

  // answer only at the alert response address while alert is up
  assign ara_only = cfg_q[`PMSC_CFG_ARA_BIT] & alert_active;
  // pin function decode
  assign trim_or_control_pin_is_onoff = (cfg_q[3:0] == 4'h0);
  assign trim_or_control_pin_is_trim = (cfg_q[3:0] == 4'h1) |
                                       (cfg_q[3:0] == 4'h2);
  // second control pin: power good or secondary on/off
  assign second_control_pin_is_pgood = (cfg_q[3:0] == 4'h0) |
                                       (cfg_q[3:0] == 4'h1);
  assign second_control_pin_is_onoff = (cfg_q[3:0] == 4'h2);

  // ----------------------------------------------------------------
  // command answer
  // ----------------------------------------------------------------
  // read data and done pulse one edge after the request
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_rdata_q <= 16'h0000;
      cmd_done_q <= 1'b0;
    end
    else
    begin
      // done follows every request by one edge
      cmd_done_q <= cmd_valid;
      // read data stands until the next read
      if (rd)
        cmd_rdata_q <= known ? rd_value : 16'h0000;
    end
  end

endmodule // pmsc_bank

/* File: testbench/pmsc_host.sv */
// host model that issues one bank command at a time
`timescale 1ns/1ps
module pmsc_host
(
  // clock
  input logic clk,
  // command side towards the bank
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  // answer side from the bank
  input logic [15:0] cmd_rdata_q,
  input logic cmd_done_q
);
  // idle bus from time zero
  initial
  begin
    cmd_valid = 1'h0;
    cmd_write = 1'h0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end

  // one command: strobe for a cycle, then take the answer
  task automatic xfer(input logic w, input logic [7:0] c,
    input logic [15:0] d, output logic [15:0] r, output logic ok);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clk);
    // released lines show the inverse, not the old value
    cmd_valid <= 1'h0;
    cmd_write <= ~w;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    #1;
    ok = cmd_done_q;
    r = cmd_rdata_q;
  endtask
endmodule // pmsc_host

/* File: testbench/pmsc_bank_sva.sv */
// port assertions for the status and trim command bank
`timescale 1ns/1ps
module pmsc_bank_sva
#(
  parameter [7:0] FW_REVISION = 8'h10,
  parameter [5:0] DESIGNATION = 6'h2a,
  parameter LOAD_SHARE = 0
)
(
  // clock and reset
  input wire clk,
  input wire resetn,
  // command port
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  input wire [15:0] cmd_rdata_q,
  input wire cmd_done_q,
  // events and summaries
  input wire over_temperature_fault_flag_evt,
  input wire pec_error_evt,
  input wire alert_active,
  input wire temp_summary,
  input wire comm_summary,
  // trims and configuration
  input wire [15:0] vout_read_gain_trim_q,
  input wire [15:0] vout_read_offset_trim_q,
  input wire [15:0] iout_gain_trim_q,
  input wire write_protect_flag,
  input wire ara_only,
  input wire trim_or_control_pin_is_trim,
  input wire trim_or_control_pin_is_onoff,
  input wire second_control_pin_is_pgood,
  input wire second_control_pin_is_onoff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // write and read requests
  wire wr = cmd_valid && cmd_write;
  wire rd = cmd_valid && !cmd_write;

  a_done_pulse: assert property (1 |=>
    cmd_done_q == $past(cmd_valid))
    else $error("done does not follow request");
  a_temp_latch: assert property (over_temperature_fault_flag_evt |=> temp_summary)
    else $error("temperature fault not latched");
  a_pec_latch: assert property (pec_error_evt |=> comm_summary)
    else $error("pec error not latched");
  a_summary_keep: assert property (temp_summary &&
    !(wr && cmd_code == 8'h7d) |=> temp_summary)
    else $error("temperature summary dropped");
  a_ro_refused: assert property (wr && cmd_code == 8'hdb |=>
    comm_summary)
    else $error("revision write not flagged");
  a_reserved_zero: assert property (rd && cmd_code == 8'h7d |=>
    cmd_rdata_q[5:0] == 6'h00 && cmd_rdata_q[15:8] == 8'h00)
    else $error("reserved temperature bits set");
  a_wp_lock: assert property (wr && write_protect_flag &&
    cmd_code == 8'hd1 |=> $stable(vout_read_gain_trim_q))
    else $error("protected gain changed");
  a_gain_range: assert property (
    vout_read_gain_trim_q >= 16'h1999 &&
    vout_read_gain_trim_q <= 16'h2666 && iout_gain_trim_q >= 16'h1999 &&
    iout_gain_trim_q <= 16'h2666)
    else $error("gain outside limits");
  a_offset_exp: assert property (wr && cmd_code == 8'hd2 &&
    cmd_wdata[15:11] != 5'h14 |=> $stable(vout_read_offset_trim_q))
    else $error("offset with wrong exponent taken");
  a_fw_read: assert property (rd && cmd_code == 8'hdb |=>
    cmd_rdata_q == {8'h00, FW_REVISION})
    else $error("revision read wrong");
  a_type_read: assert property (rd && cmd_code == 8'hd0 |=>
    cmd_rdata_q[15:8] == 8'h00 && cmd_rdata_q[7] == DESIGNATION[5] &&
    !cmd_rdata_q[0])
    else $error("module type fixed bits wrong");
  a_ara_gate: assert property (ara_only |-> alert_active)
    else $error("alert address only without alert");
  a_pin_decode: assert property (trim_or_control_pin_is_trim !=
    trim_or_control_pin_is_onoff && second_control_pin_is_pgood !=
    second_control_pin_is_onoff && !(trim_or_control_pin_is_onoff &&
    second_control_pin_is_onoff))
    else $error("pin functions inconsistent");

  // main scenarios reached
  c_fw_read: cover property (rd && cmd_code == 8'hdb);
  c_wp_write: cover property (wr && write_protect_flag && cmd_code == 8'hd1);
  c_pec: cover property (pec_error_evt);
  c_ara: cover property (ara_only);
endmodule // pmsc_bank_sva

bind pmsc_bank pmsc_bank_sva #(.FW_REVISION(FW_REVISION),
  .DESIGNATION(DESIGNATION), .LOAD_SHARE(LOAD_SHARE)) u_sva (.*);

/* File: testbench/pmsc_bank_test.sv */
// self-checking bench for the status and trim command bank
`timescale 1ns/1ps
module pmsc_bank_test;
  localparam logic [7:0] FW = 8'h10;
  localparam logic [5:0] DG = 6'h2a;
  // bench signals, named as the bank ports
  logic clk, resetn, over_temperature_fault_flag_evt, over_temperature_warning_flag_evt, pec_error_evt, alert_active;
  wire cmd_valid, cmd_write, cmd_done_q, temp_summary, comm_summary;
  wire write_protect_flag, ara_only, trim_or_control_pin_is_trim;
  wire trim_or_control_pin_is_onoff, second_control_pin_is_pgood;
  wire second_control_pin_is_onoff;
  wire [7:0] cmd_code;
  wire [15:0] cmd_wdata, cmd_rdata_q;
  // calibration outputs and the load sharing build's observed pins
  wire [15:0] vout_read_gain_trim_q, vout_read_offset_trim_q;
  wire [15:0] vin_read_gain_trim_q, vin_read_offset_trim_q;
  wire [15:0] iout_gain_trim_q, iout_offset_trim_q;
  wire ls_pin_onoff, ls_comm_summary;
  logic [15:0] rdg [4] = '{16'h1234, 16'h4c21, 16'h0a5f, 16'h1b3e};
  logic [7:0] tel [4] = '{8'h88, 8'h8b, 8'h8c, 8'h8d};
  logic [7:0] oc [3] = '{8'hd2, 8'hd4, 8'hd7};
  logic [4:0] ex [3] = '{5'h14, 5'h1d, 5'h1c};
  integer fails, cmp_count;

  pmsc_bank #(.FW_REVISION(FW), .DESIGNATION(DG)) dut (
    .clk(clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata_q(cmd_rdata_q),
    .cmd_done_q(cmd_done_q),
    .over_temperature_fault_flag_evt(over_temperature_fault_flag_evt), .over_temperature_warning_flag_evt(over_temperature_warning_flag_evt),
    .pec_error_evt(pec_error_evt), .alert_active(alert_active),
    .vin_reading(rdg[0]), .vout_reading(rdg[1]), .iout_reading(rdg[2]),
    .temp_reading(rdg[3]),
    .temp_summary(temp_summary), .comm_summary(comm_summary),
    .vout_read_gain_trim_q(vout_read_gain_trim_q),
    .vout_read_offset_trim_q(vout_read_offset_trim_q),
    .vin_read_gain_trim_q(vin_read_gain_trim_q),
    .vin_read_offset_trim_q(vin_read_offset_trim_q),
    .iout_gain_trim_q(iout_gain_trim_q),
    .iout_offset_trim_q(iout_offset_trim_q),
    .write_protect_flag(write_protect_flag), .ara_only(ara_only),
    .trim_or_control_pin_is_trim(trim_or_control_pin_is_trim),
    .trim_or_control_pin_is_onoff(trim_or_control_pin_is_onoff),
    .second_control_pin_is_pgood(second_control_pin_is_pgood),
    .second_control_pin_is_onoff(second_control_pin_is_onoff));
  // load sharing build sees the same commands, pin code 0 only
  pmsc_bank #(.FW_REVISION(FW), .DESIGNATION(DG), .LOAD_SHARE(1)) dut_ls (
    .clk(clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata_q(), .cmd_done_q(),
    .over_temperature_fault_flag_evt(over_temperature_fault_flag_evt), .over_temperature_warning_flag_evt(over_temperature_warning_flag_evt),
    .pec_error_evt(pec_error_evt), .alert_active(alert_active),
    .vin_reading(rdg[0]), .vout_reading(rdg[1]), .iout_reading(rdg[2]),
    .temp_reading(rdg[3]), .temp_summary(), .comm_summary(ls_comm_summary),
    .vout_read_gain_trim_q(), .vout_read_offset_trim_q(),
    .vin_read_gain_trim_q(), .vin_read_offset_trim_q(),
    .iout_gain_trim_q(), .iout_offset_trim_q(),
    .write_protect_flag(), .ara_only(),
    .trim_or_control_pin_is_trim(),
    .trim_or_control_pin_is_onoff(ls_pin_onoff),
    .second_control_pin_is_pgood(), .second_control_pin_is_onoff());
  pmsc_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata_q(cmd_rdata_q), .cmd_done_q(cmd_done_q));

  // 200 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // value compare
  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // read one command and compare
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] r;
    logic ok;
    host.xfer(1'h0, c, 16'h0000, r, ok);
    chk("done", 16'h0001, {15'h0000, ok});
    chk($sformatf("read %h", c), e, r);
  endtask

  // write one command
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic ok;
    host.xfer(1'h1, c, d, r, ok);
    chk("done", 16'h0001, {15'h0000, ok});
  endtask

  // reset values and telemetry
  task automatic t_defaults;
    rd(8'hd1, 16'h2000);
    rd(8'hd3, 16'h2000);
    rd(8'hd0, {8'h00, DG[5], 5'h00, 2'h2});
    rd(8'he0, 16'h0000);
    rd(8'hdb, {8'h00, FW});
    rd(8'h7d, 16'h0000);
    rd(8'h7e, 16'h0000);
    for (int i = 0; i < 4; i++)
      rd(tel[i], rdg[i]);
    $display("test defaults done");
  endtask

  // write protect and gain limits
  task automatic t_protect;
    wr(8'hd1, 16'h2100);
    rd(8'hd1, 16'h2000);
    chk("vg out", 16'h2000, vout_read_gain_trim_q);
    rd(8'h7e, 16'h0040);
    wr(8'h7e, 16'h00ff);
    rd(8'h7e, 16'h0000);
    wr(8'hd0, 16'h0000);
    rd(8'hd0, {8'h00, DG[5], 7'h00});
    chk("protect", 16'h0000, {15'h0000, write_protect_flag});
    wr(8'hd1, 16'h2666);
    rd(8'hd1, 16'h2666);
    chk("vg out", 16'h2666, vout_read_gain_trim_q);
    wr(8'hd3, 16'h1999);
    rd(8'hd3, 16'h1999);
    chk("vig out", 16'h1999, vin_read_gain_trim_q);
    wr(8'hd6, 16'h2667);
    wr(8'hd6, 16'h1998);
    rd(8'hd6, 16'h2000);
    chk("ig out", 16'h2000, iout_gain_trim_q);
    rd(8'h7e, 16'h0040);
    wr(8'h7e, 16'h0040);
    $display("test protect done");
  endtask

  // offset exponents, good then bad
  task automatic t_offset;
    for (int i = 0; i < 3; i++)
    begin
      wr(oc[i], {ex[i], 11'h2a5});
      rd(oc[i], {ex[i], 11'h2a5});
      wr(oc[i], {ex[i] ^ 5'h01, 11'h000});
      rd(oc[i], {ex[i], 11'h2a5});
      rd(8'h7e, 16'h0040);
      wr(8'h7e, 16'h0040);
    end
    chk("vo out", {5'h14, 11'h2a5}, vout_read_offset_trim_q);
    chk("vi out", {5'h1d, 11'h2a5}, vin_read_offset_trim_q);
    chk("io out", {5'h1c, 11'h2a5}, iout_offset_trim_q);
    $display("test offset done");
  endtask

  // status latching, clearing and refused commands
  task automatic t_status;
    @(posedge clk);
    over_temperature_fault_flag_evt <= 1'h1;
    over_temperature_warning_flag_evt <= 1'h1;
    pec_error_evt <= 1'h1;
    @(posedge clk);
    over_temperature_fault_flag_evt <= 1'h0;
    over_temperature_warning_flag_evt <= 1'h0;
    pec_error_evt <= 1'h0;
    rd(8'h7d, 16'h00c0);
    chk("temp sum", 16'h0001, {15'h0000, temp_summary});
    wr(8'h7d, 16'h0080);
    rd(8'h7d, 16'h0040);
    wr(8'h7d, 16'h0040);
    chk("temp sum", 16'h0000, {15'h0000, temp_summary});
    rd(8'h90, 16'h0000);
    wr(8'hdb, 16'h00ff);
    rd(8'hdb, {8'h00, FW});
    rd(8'h7e, 16'h00a0);
    chk("comm sum", 16'h0001, {15'h0000, comm_summary});
    wr(8'h7e, 16'h00ff);
    chk("comm sum", 16'h0000, {15'h0000, comm_summary});
    $display("test status done");
  endtask

  // pin codes, refused code and alert address mode
  task automatic t_config;
    for (int c = 0; c < 3; c++)
    begin
      wr(8'he0, 16'(c));
      rd(8'he0, 16'(c));
      chk("pins", {12'h000, c != 0, c == 0, c != 2, c == 2},
        {12'h000, trim_or_control_pin_is_trim, trim_or_control_pin_is_onoff,
        second_control_pin_is_pgood, second_control_pin_is_onoff});
      chk("ls pins", {14'h0000, c != 0, 1'b1},
        {14'h0000, ls_comm_summary, ls_pin_onoff});
    end
    wr(8'he0, 16'h0003);
    rd(8'he0, 16'h0002);
    rd(8'h7e, 16'h0040);
    wr(8'he0, 16'h0010);
    @(posedge clk);
    alert_active <= 1'h1;
    #1;
    chk("ara", 16'h0001, {15'h0000, ara_only});
    wr(8'he0, 16'h0000);
    chk("ara", 16'h0000, {15'h0000, ara_only});
    $display("test config done");
  endtask

  // reset in mid-run restores the defaults
  task automatic t_reset;
    @(posedge clk);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    rd(8'hd0, {8'h00, DG[5], 5'h00, 2'h2});
    rd(8'he0, 16'h0000);
    rd(8'h7e, 16'h0000);
    chk("vg out", 16'h2000, vout_read_gain_trim_q);
    $display("test reset done");
  endtask

  // verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done;
  end

  // main sequence
  initial
  begin
    fails = 0;
    cmp_count = 0;
    resetn = 1'h0;
    over_temperature_fault_flag_evt = 1'h0;
    over_temperature_warning_flag_evt = 1'h0;
    pec_error_evt = 1'h0;
    alert_active = 1'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    t_defaults;
    t_protect;
    t_offset;
    t_status;
    t_config;
    t_reset;
    test_done;
  end
endmodule // pmsc_bank_test
